//--- src/sacc_top.sv
// Conversion control and host bus interface of a 12-bit sampling converter
// Summary of operation
// - Lockstep mode: start only when chip select and start strobe are both low.
// - Free mode: start on start strobe falling edge, chip select ignored.
// - Idle: done high, sampler tracks; start: sampler holds, done goes low.
// - Sampler returns to track mid conversion; done rises when result completes.
// - Data lines driven only while chip select and output enable are low.
// - Wide format puts all 12 result bits on the lines at once.
// - Byte format: two lowest lines are inputs for justify and byte select.
// - Byte format: upper eight lines carry data, high byte read first.
// - Right justified: high byte is four extension bits and top nibble.
// - Unipolar gives straight binary, bipolar gives twos complement.
// - Lockstep mode: done flag driven only with chip select and enable low.
// - Free mode: done flag open drain, pulls low while converting if enabled.
// - Internal logic finishes reset about 10 us after power-up.
// - Wide format select high picks 12-bit output, low picks byte output.
`timescale 1ns/1ps
`include "sacc_consts.svh"
module sacc_top import sacc_pkg::*; #(
  parameter int CONV_CYCLES = `SACC_CONV_NS / `SACC_CLK_NS,
  parameter int TRACK_CYCLES = `SACC_TRACK_NS / `SACC_CLK_NS,
  parameter int PWRUP_CYCLES = `SACC_PWRUP_NS / `SACC_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic lockstep_mode,
  input wire logic wide_format_select,
  input wire logic bipolar_offset_pin,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic start_convert_n,
  input wire logic done_flag_enable_n,
  input wire logic [11:0] analog_code,
  input wire logic [11:0] data_bits_in,
  output logic [11:0] data_bits_out,
  output logic [11:0] data_bits_oe,
  output logic conversion_done_out,
  output logic conversion_done_oe,
  output logic sampler_hold,
  output logic logic_ready
);
  localparam int CW = $clog2(PWRUP_CYCLES + CONV_CYCLES + 1);

  // Byte lane selection for the narrow bus
  // Extension bits copy the sign only for a signed (bipolar) code
  function automatic logic [7:0] sacc_byte(input logic [11:0] c, input logic jr,
                                           input logic hbe_n, input logic bip);
    logic [3:0] ext;
    ext = (bip && c[11]) ? 4'hF : 4'h0; // Unipolar pads with zeros
    if (jr)
      sacc_byte = hbe_n ? c[7:0] : {ext, c[11:8]};
    else
      sacc_byte = hbe_n ? {c[3:0], 4'h0} : c[11:4];
  endfunction : sacc_byte

  sacc_bus_t bus;
  sacc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic sc_prev_r, lk_prev_r, ready_r;
  sacc_word_t mem_r [2];
  logic wr_ptr_r, rd_ptr_r;
  logic [1:0] fill_r;
  sacc_word_t res_r;

  assign bus = '{cs_n: chip_select_n, oe_n: output_enable_n, sc_n: start_convert_n,
                 done_flag_enable_n_n: done_flag_enable_n};

  // Start detection; a held-low strobe re-triggers only in lockstep mode, on a new chip select fall
  wire lk_cond = !bus.cs_n && !bus.sc_n;
  wire start_lk = lockstep_mode && lk_cond && !lk_prev_r;
  wire start_fr = !lockstep_mode && sc_prev_r && !bus.sc_n;
  wire start = ready_r && (state_r == SACC_IDLE) && (start_lk || start_fr);
  wire conv_end = (state_r == SACC_TRACK) && (cnt_r == CW'(CONV_CYCLES - 1));
  wire buf_in_rdy = (fill_r != 2'd2);
  wire push = conv_end && buf_in_rdy; // Full buffer stalls the finish
  wire reading = !bus.cs_n && !bus.oe_n;
  wire pop = (fill_r != 2'd0) && !reading; // No word change under a read
  // Offset binary becomes twos complement by flipping the sign bit
  wire [11:0] enc = bipolar_offset_pin ? {~analog_code[11], analog_code[10:0]}
                                       : analog_code;
  wire [7:0] byte_sel = sacc_byte(res_r.code, data_bits_in[`SACC_JR_BIT],
                                  data_bits_in[`SACC_HBE_BIT],
                                  bipolar_offset_pin);
  wire [11:0] dout = wide_format_select ? res_r.code
                                        : {byte_sel, `SACC_NIB_W'(0)};
  wire [11:0] doe = !reading ? `SACC_ZERO12 :
                    (wide_format_select ? `SACC_ONES12 : `SACC_BYTE_OE);
  wire converting = (state_r != SACC_IDLE);
  wire eoc_oe = lockstep_mode ? (!bus.cs_n && !bus.done_flag_enable_n_n)
                              : (converting && !bus.done_flag_enable_n_n);
  wire eoc_val = lockstep_mode && !converting;

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      SACC_IDLE: begin
        cnt_nxt = '0;
        if (start)
          state_nxt = SACC_HOLD;
      end
      SACC_HOLD: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r == CW'(TRACK_CYCLES - 1))
          state_nxt = SACC_TRACK;
      end
      SACC_TRACK: begin
        if (push)
          state_nxt = SACC_IDLE;
        else if (!conv_end)
          cnt_nxt = cnt_r + CW'(1);
      end
      default: state_nxt = SACC_IDLE;
    endcase
  end

  // Power-up counter shares the conversion counter width
  logic [CW-1:0] pwr_r;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwr_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      pwr_r <= pwr_r + CW'(1);
      ready_r <= (pwr_r == CW'(PWRUP_CYCLES - 1));
    end
  end

  // State, edge history and pin registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= SACC_IDLE;
      cnt_r <= '0;
      sc_prev_r <= 1'b1;
      lk_prev_r <= 1'b1;
      data_bits_out <= `SACC_ZERO12;
      data_bits_oe <= `SACC_ZERO12;
      conversion_done_out <= 1'b0;
      conversion_done_oe <= 1'b0;
      sampler_hold <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sc_prev_r <= bus.sc_n;
      lk_prev_r <= lk_cond;
      data_bits_out <= dout;
      data_bits_oe <= doe;
      conversion_done_out <= eoc_val;
      conversion_done_oe <= eoc_oe;
      sampler_hold <= (state_nxt == SACC_HOLD);
    end
  end
  assign logic_ready = ready_r;

  // Two-entry result buffer; output register refills only between reads
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fill_r <= 2'd0;
      res_r <= '0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= '{code: enc};
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop) begin
        res_r <= mem_r[rd_ptr_r];
        rd_ptr_r <= !rd_ptr_r;
      end
      fill_r <= fill_r + 2'(push) - 2'(pop);
    end
  end

  // Length of the current hold phase; lets the track check follow TRACK_CYCLES
  // instead of a fixed repetition count that breaks with small parameters
  logic [CW-1:0] hold_len_r;
  always_ff @(posedge core_clk) begin
    if (!rstn)
      hold_len_r <= '0;
    else if (sampler_hold)
      hold_len_r <= hold_len_r + CW'(1);
    else
      hold_len_r <= '0;
  end

  // Rule checks; all share the one clock and the synchronous reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_LOCK_START: assert property (lockstep_mode && ready_r && state_r == SACC_IDLE
      && bus.cs_n |=> state_r == SACC_IDLE) else $error("start without select");
  AST_FREE_START: assert property (!lockstep_mode && start_fr && ready_r &&
      state_r == SACC_IDLE |=> state_r == SACC_HOLD) else $error("edge missed");
  AST_HOLD_ON_START: assert property (start |=> ##1
      sampler_hold && !conversion_done_out) else $error("no hold on start");
  AST_TRACK_BACK: assert property ($fell(sampler_hold) |->
      hold_len_r == CW'(TRACK_CYCLES)) else $error("hold length wrong");
  AST_DATA_HIZ: assert property (bus.cs_n || bus.oe_n |=>
      data_bits_oe == `SACC_ZERO12) else $error("data driven outside read");
  AST_WIDE_OUT: assert property (reading && wide_format_select |=>
      data_bits_oe == `SACC_ONES12 && data_bits_out == $past(res_r.code))
      else $error("wide word wrong");
  AST_BYTE_LOW_IN: assert property (!wide_format_select |=>
      data_bits_oe[1:0] == 2'h0) else $error("select lines driven");
  AST_EOC_SYNC: assert property (lockstep_mode && !bus.cs_n && !bus.done_flag_enable_n_n |=>
      conversion_done_oe && conversion_done_out == $past(!converting))
      else $error("done flag wrong");
  AST_EOC_OD: assert property (!lockstep_mode |=> !conversion_done_out)
      else $error("open drain drove high");
  AST_PWRUP: assert property (!ready_r |-> state_r == SACC_IDLE)
      else $error("start before ready");
  COV_LOCK: cover property (start_lk && start);
  COV_FREE: cover property (start_fr && start);
  COV_STALL: cover property (conv_end && !buf_in_rdy);
  COV_BYTE: cover property (reading && !wide_format_select);
endmodule : sacc_top

//--- src/sacc_consts.svh
// Timing and layout constants of the sampling converter control block
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH
`define SACC_CLK_NS 50
`define SACC_CONV_NS 4000
`define SACC_TRACK_NS 2000
`define SACC_PWRUP_NS 10000
`define SACC_RES_W 12
`define SACC_BYTE_W 8
`define SACC_NIB_W 4
`define SACC_JR_BIT 1
`define SACC_HBE_BIT 0
`define SACC_ZERO12 12'h000
`define SACC_ONES12 12'hFFF
`define SACC_BYTE_OE 12'hFF0
`endif

//--- src/sacc_pkg.sv
// Types shared by the sampling converter control block
package sacc_pkg;
  // Host strobes grouped as sampled on the pins
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic sc_n;
    logic done_flag_enable_n_n;
  } sacc_bus_t;
  // One finished conversion word
  typedef struct packed {
    logic [11:0] code;
  } sacc_word_t;
  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_HOLD = 2'b01,
    SACC_TRACK = 2'b10
  } sacc_state_t;
endpackage : sacc_pkg

//--- tb/sacc_host.sv
// Host side model: resolves the shared data and done lines
`timescale 1ns/1ps
module sacc_host (
  input wire logic core_clk,
  input wire logic lockstep_mode,
  input wire logic wide_format_select,
  input wire logic [1:0] host_bits,
  input wire logic [11:0] data_bits_out,
  input wire logic [11:0] data_bits_oe,
  input wire logic conversion_done_out,
  input wire logic conversion_done_oe,
  output logic [11:0] data_wire,
  output logic done_wire
);
  logic tog_r = 1'b0;
  // Floating lines wiggle so a stale level never passes for data
  always_ff @(posedge core_clk) tog_r <= ~tog_r;
  // Wire levels from every driver's enable
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      data_wire[i] = data_bits_oe[i] ? data_bits_out[i] : tog_r;
    end
    if (!wide_format_select) data_wire[1:0] = host_bits;
    // Board pull-up only in free mode
    done_wire = conversion_done_oe ? conversion_done_out : (lockstep_mode ? tog_r : 1'b1);
  end
endmodule : sacc_host

//--- tb/sacc_top_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module sacc_top_bench;
  logic core_clk = 1'b0, rstn = 1'b0, lk = 1'b0, wd = 1'b1, bp = 1'b0;
  logic cs_n = 1'b1, oe_n = 1'b1, sc_n = 1'b1, en_n = 1'b0;
  logic [1:0] hb = 2'b00;
  logic [11:0] code = 12'h000, dw, dout, doe, v;
  logic dno, dnoe, hold, rdy, dn;
  int err_total = 0, total_checks = 0;
  // Mode nibble {lockstep, wide, bipolar, justify}, code, first and second read
  logic [39:0] rows [6] = '{40'h4A5CA5C000, 40'hEA5C25C000, 40'h1A5C00A05C,
                            40'h8A5C0A50C0, 40'h335C0FB05C, 40'hA35C0B50C0};
  always #25 core_clk = ~core_clk;
  sacc_top #(.CONV_CYCLES(8), .TRACK_CYCLES(4), .PWRUP_CYCLES(4)) u_sacc_top (
    .core_clk(core_clk), .rstn(rstn), .lockstep_mode(lk), .wide_format_select(wd),
    .bipolar_offset_pin(bp), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .start_convert_n(sc_n), .done_flag_enable_n(en_n), .analog_code(code),
    .data_bits_in(dw), .data_bits_out(dout), .data_bits_oe(doe),
    .conversion_done_out(dno), .conversion_done_oe(dnoe), .sampler_hold(hold),
    .logic_ready(rdy));
  sacc_host u_sacc_host (.core_clk(core_clk), .lockstep_mode(lk), .wide_format_select(wd),
    .host_bits(hb), .data_bits_out(dout), .data_bits_oe(doe), .conversion_done_out(dno),
    .conversion_done_oe(dnoe), .data_wire(dw), .done_wire(dn));
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // Bounded wait for the done line; running out ends the run
  task automatic wdn(input logic lv);
    int n;
    n = 0;
    while (dn !== lv) begin
      @(negedge core_clk);
      n++;
      if (n > 40) begin
        err_total++;
        summarize();
      end
    end
  endtask : wdn
  // Chip select held low only where lockstep needs it
  task automatic conv(input logic [11:0] c);
    code = c;
    cs_n = ~lk;
    @(negedge core_clk);
    sc_n = 1'b0;
    repeat (3) @(negedge core_clk);
    sc_n = 1'b1;
    chk({10'h000, dn, hold}, 12'h001);
    repeat (5) @(negedge core_clk);
    chk({10'h000, dn, hold}, 12'h000);
    wdn(1'b1);
    repeat (100) @(negedge core_clk);
  endtask : conv
  task automatic rd(input logic h, output logic [11:0] r);
    hb[0] = h;
    cs_n = 1'b0;
    @(negedge core_clk);
    oe_n = 1'b0;
    repeat (2) @(negedge core_clk);
    r = dw;
    oe_n = 1'b1;
    cs_n = 1'b1;
    @(negedge core_clk);
  endtask : rd
  initial begin
    repeat (20) @(negedge core_clk);
    chk(doe, 12'h000);
    chk({11'h000, dnoe}, 12'h000);
    rstn = 1'b1;
    sc_n = 1'b0;
    repeat (6) @(negedge core_clk);
    sc_n = 1'b1;
    chk({10'h000, rdy, hold}, 12'h002);
    foreach (rows[i]) begin
      {lk, wd, bp, hb[1]} = rows[i][39:36];
      conv(rows[i][35:24]);
      rd(1'b0, v);
      if (wd) chk(v, rows[i][23:12]);
      else begin
        chk({4'h0, v[11:4]}, rows[i][23:12]);
        rd(1'b1, v);
        chk({4'h0, v[11:4]}, rows[i][11:0]);
      end
      chk(doe, 12'h000);
    end
    // Lockstep start without chip select, output enable alone
    lk = 1'b1;
    oe_n = 1'b0;
    sc_n = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(doe, 12'h000);
    chk({11'h000, hold}, 12'h000);
    en_n = 1'b1;
    cs_n = 1'b0;
    @(negedge core_clk);
    chk({11'h000, dnoe}, 12'h000);
    {sc_n, oe_n, cs_n, lk, en_n} = 5'h1C;
    repeat (2) @(negedge core_clk);
    // Select joining the held strobe started a conversion: open drain pulls low
    chk({10'h000, dn, dnoe}, 12'h001);
    wdn(1'b1);
    chk({10'h000, dn, dnoe}, 12'h002);
    repeat (100) @(negedge core_clk);
    // Reset in mid conversion, while the sampler holds, drops hold and done drive
    sc_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({10'h000, dnoe, hold}, 12'h003);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({10'h000, dnoe, hold}, 12'h000);
    summarize();
  end
endmodule : sacc_top_bench
